// File: dpram_core.sv
// two-port synchronous ram core with burst counters and deselect power-down
`include "dpram_params.svh"
`timescale 1ns/1ps
module dpram_core
  import dpram_pkg::*;
#(
  parameter int ADDR_W = `DPRAM_ADDR_W_LARGE,
  parameter int DATA_W = `DPRAM_WORD_W
) (
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire logic                  global_async_reset_n,
  input  wire dpram_pkg::dpram_req_t reqA,
  input  wire dpram_pkg::dpram_req_t reqB,
  output logic [DATA_W-1:0]          rdDataA_ff,
  output logic [DATA_W-1:0]          rdDataB_ff,
  output logic                       rdOeNA_ff,
  output logic                       rdOeNB_ff,
  output logic [ADDR_W-1:0]          burstAddrA_ff,
  output logic [ADDR_W-1:0]          burstAddrB_ff
);
  import dpram_pkg::*;

  dpram_req_t reqMetaA_ff, reqMetaB_ff, reqA_ff, reqB_ff;
  logic       rstMeta_ff, rstSync_ff;
  wire logic  coreRstN = nrst & rstSync_ff;

  // async reset released through a synchroniser; asserts without the clock
  always_ff @(posedge ref_clk or negedge global_async_reset_n)
  begin
    if (!global_async_reset_n)
    begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end
    else
    begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end

  // pins pass two flops; the second stage is the documented input register
  always_ff @(posedge ref_clk)
  begin
    reqMetaA_ff <= reqA;
    reqMetaB_ff <= reqB;
    reqA_ff     <= reqMetaA_ff;
    reqB_ff     <= reqMetaB_ff;
  end

  logic [ADDR_W-1:0] memAddr [2];
  logic              memEn   [2];
  logic              memWe   [2];
  logic [DATA_W-1:0] memRd   [2];
  dpram_req_t        req     [2];
  assign req[0] = reqA_ff;
  assign req[1] = reqB_ff;

  logic [ADDR_W-1:0] burstAddr [2];
  logic              oeN [2];

  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_port
      dpram_pwr_t        pwr_ff, nxt_pwr;
      logic [ADDR_W-1:0] cnt_ff, nxt_cnt;
      logic              oeN_ff;
      wire logic selected = !req[p].chipEnableActiveLowN && req[p].chipEnableActiveHigh;
      wire logic [ADDR_W-1:0] extAddr = req[p].addr[ADDR_W-1:0];
      wire logic [ADDR_W-1:0] accAddr = req[p].loadAddr ? extAddr : cnt_ff;

      // load wins over increment; counter holds otherwise
      assign nxt_cnt = !selected ? cnt_ff :
                       req[p].loadAddr ? extAddr + ADDR_W'(1) :
                       req[p].incAddr  ? cnt_ff + ADDR_W'(1) : cnt_ff;

      always_comb
      begin
        nxt_pwr = pwr_ff;
        case (pwr_ff)
          DPRAM_ST_ACTIVE: if (!selected) nxt_pwr = DPRAM_ST_DESEL;
          DPRAM_ST_DESEL:  if (selected)  nxt_pwr = DPRAM_ST_REACT;
          DPRAM_ST_REACT:  nxt_pwr = selected ? DPRAM_ST_ACTIVE : DPRAM_ST_DESEL;
          default:         nxt_pwr = DPRAM_ST_DESEL;
        endcase
      end

      // only accesses in the active state touch the array
      assign memEn[p]   = selected && (pwr_ff == DPRAM_ST_ACTIVE);
      assign memWe[p]   = req[p].writeEn;
      assign memAddr[p] = accAddr;

      always_ff @(posedge ref_clk)
      begin
        if (!coreRstN)
        begin
          pwr_ff    <= DPRAM_ST_DESEL;
          cnt_ff    <= ADDR_W'(`DPRAM_ADDR_RST);
          oeN_ff    <= 1'b1;
        end
        else
        begin
          pwr_ff    <= nxt_pwr;
          cnt_ff    <= nxt_cnt;
          // enable tracks the array register so it lines up with read data
          oeN_ff    <= !(memEn[p] && !memWe[p]);
        end
      end
      assign burstAddr[p] = cnt_ff;
      assign oeN[p]       = oeN_ff;
    end
  endgenerate

  dpram_mem #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_mem (
    .ref_clk (ref_clk),
    .enA     (memEn[0]),
    .weA     (memWe[0]),
    .addrA   (memAddr[0]),
    .wdA     (reqA_ff.wrData[DATA_W-1:0]),
    .rdA_ff  (memRd[0]),
    .enB     (memEn[1]),
    .weB     (memWe[1]),
    .addrB   (memAddr[1]),
    .wdB     (reqB_ff.wrData[DATA_W-1:0]),
    .rdB_ff  (memRd[1])
  );

  // output register stage after the array register
  always_ff @(posedge ref_clk)
  begin
    if (!coreRstN)
    begin
      rdDataA_ff    <= '0;
      rdDataB_ff    <= '0;
      rdOeNA_ff     <= 1'b1;
      rdOeNB_ff     <= 1'b1;
      burstAddrA_ff <= '0;
      burstAddrB_ff <= '0;
    end
    else
    begin
      rdDataA_ff    <= memRd[0];
      rdDataB_ff    <= memRd[1];
      rdOeNA_ff     <= oeN[0];
      rdOeNB_ff     <= oeN[1];
      burstAddrA_ff <= burstAddr[0];
      burstAddrB_ff <= burstAddr[1];
    end
  end
endmodule // dpram_core

// File: dpram_core_props.sv
// port assertions for the ram core
`timescale 1ns/1ps
module dpram_core_props
  import dpram_pkg::*;
(
  input wire logic                  ref_clk,
  input wire logic                  nrst,
  input wire logic                  global_async_reset_n,
  input wire dpram_pkg::dpram_req_t reqA,
  input wire dpram_pkg::dpram_req_t reqB,
  input wire logic [71:0]           rdDataA_ff,
  input wire logic [71:0]           rdDataB_ff,
  input wire logic                  rdOeNA_ff,
  input wire logic                  rdOeNB_ff,
  input wire logic [17:0]           burstAddrA_ff,
  input wire logic [17:0]           burstAddrB_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst || !global_async_reset_n);
  wire sA = !reqA.chipEnableActiveLowN && reqA.chipEnableActiveHigh;
  wire sB = !reqB.chipEnableActiveLowN && reqB.chipEnableActiveHigh;
  property p_rdA; sA [*2] ##1 sA && !reqA.writeEn |-> ##4 !rdOeNA_ff; endproperty
  property p_rdB; sB [*2] ##1 sB && !reqB.writeEn |-> ##4 !rdOeNB_ff; endproperty
  property p_offA; !sA |-> ##4 rdOeNA_ff; endproperty
  property p_offB; !sB |-> ##4 rdOeNB_ff; endproperty
  property p_ldA; sA [*2] ##1 sA && reqA.loadAddr |->
    ##4 burstAddrA_ff == $past(reqA.addr, 4) + 18'h1; endproperty
  property p_ldB; sB [*2] ##1 sB && reqB.loadAddr |->
    ##4 burstAddrB_ff == $past(reqB.addr, 4) + 18'h1; endproperty
  property p_holdA; rdOeNA_ff |-> $stable(rdDataA_ff); endproperty
  property p_holdB; rdOeNB_ff |-> $stable(rdDataB_ff); endproperty
  a_rdA: assert property (p_rdA) else $error("rdA");
  a_rdB: assert property (p_rdB) else $error("rdB");
  a_offA: assert property (p_offA) else $error("offA");
  a_offB: assert property (p_offB) else $error("offB");
  a_ldA: assert property (p_ldA) else $error("ldA");
  a_ldB: assert property (p_ldB) else $error("ldB");
  a_holdA: assert property (p_holdA) else $error("holdA");
  a_holdB: assert property (p_holdB) else $error("holdB");
  cover property (sA && sB && reqA.addr == reqB.addr);
  cover property (sA && reqA.writeEn);
  cover property (!sA);
endmodule // dpram_core_props
bind dpram_core dpram_core_props u_props (.*);

// File: dpram_master.sv
// bus master model for one port
`timescale 1ns/1ps
module dpram_master
  import dpram_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire dpram_pkg::dpram_req_t nxtReq,
  output dpram_pkg::dpram_req_t      req
);
  initial req = '0;
  // sampled at the edge so a bench update in the same step cannot race
  always @(posedge ref_clk)
    req <= #1 nxtReq;
endmodule // dpram_master

// File: dpram_mem.sv
// true dual-port storage array with registered read data
`include "dpram_params.svh"
`timescale 1ns/1ps
module dpram_mem #(
  parameter int ADDR_W = `DPRAM_ADDR_W_LARGE,
  parameter int DATA_W = `DPRAM_WORD_W
) (
  input  wire logic              ref_clk,
  input  wire logic              enA,
  input  wire logic              weA,
  input  wire logic [ADDR_W-1:0] addrA,
  input  wire logic [DATA_W-1:0] wdA,
  output logic      [DATA_W-1:0] rdA_ff,
  input  wire logic              enB,
  input  wire logic              weB,
  input  wire logic [ADDR_W-1:0] addrB,
  input  wire logic [DATA_W-1:0] wdB,
  output logic      [DATA_W-1:0] rdB_ff
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // both ports may hit the same word in one cycle
  always_ff @(posedge ref_clk)
  begin
    if (enA && weA)
      mem[addrA] <= wdA;
    if (enB && weB)
      mem[addrB] <= wdB;
  end

  always_ff @(posedge ref_clk)
  begin
    // writes leave the read register alone so read data holds between reads
    if (enA && !weA)
      rdA_ff <= mem[addrA];
    if (enB && !weB)
      rdB_ff <= mem[addrB];
  end
endmodule // dpram_mem

// File: dpram_params.svh
// timing counts, widths and reset values for the dual-port ram core
`ifndef DPRAM_PARAMS_SVH
`define DPRAM_PARAMS_SVH
`define DPRAM_WORD_W      72
`define DPRAM_ADDR_W_SMALL 17
`define DPRAM_ADDR_W_LARGE 18
`define DPRAM_REACT_CYCLES 1
`define DPRAM_ADDR_RST    18'h0_0000
`endif

// File: dpram_pkg.sv
// types shared by the dual-port ram core
package dpram_pkg;
  typedef enum logic [1:0] {DPRAM_OP_IDLE, DPRAM_OP_LOAD, DPRAM_OP_INC} dpram_addr_op_t;
  typedef struct packed {
    logic        chipEnableActiveLowN;
    logic        chipEnableActiveHigh;
    logic        writeEn;
    logic        loadAddr;
    logic        incAddr;
    logic [17:0] addr;
    logic [71:0] wrData;
  } dpram_req_t;
  typedef enum {DPRAM_ST_ACTIVE, DPRAM_ST_DESEL, DPRAM_ST_REACT} dpram_pwr_t;
endpackage

// File: tb_top.sv
// core bench
`timescale 1ns/1ps
module tb_top;
  import dpram_pkg::*;
  logic        ref_clk = 1'h0, nrst = 1'h0, rdOeNA_ff, rdOeNB_ff;
  logic [71:0] rdDataA_ff, rdDataB_ff;
  logic [17:0] burstAddrA_ff, burstAddrB_ff;
  dpram_req_t  nA = '0, nB = '0, reqA, reqB;
  wire         global_async_reset_n = nrst;
  int          bad_count = 0, n_checks = 0, cyc = 0;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc == 99) tally_and_finish(1);
  dpram_master mA (.ref_clk, .nxtReq(nA), .req(reqA));
  dpram_master mB (.ref_clk, .nxtReq(nB), .req(reqB));
  dpram_core dut (.*);
  function automatic dpram_req_t rq(logic [2:0] op, logic [17:0] a, logic [71:0] d);
    return {2'h1, op, a, d};
  endfunction
  task automatic go(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(logic [71:0] g, e);
    n_checks++;
    if (g !== e) bad_count++;
    if (g !== e) $display("ERROR t=%0t got %h exp %h", $time, g, e);
  endtask
  task automatic tally_and_finish(int x);
    bad_count += x;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_burst();
    nA = rq(3'h0, 18'h0, 72'h0);
    nB = nA;
    go(2);
    nA = rq(3'h6, 18'h3_FFFE, 72'hA_0001);
    go(1);
    nA = rq(3'h5, 18'h0, 72'hB_0002);
    go(1);
    nA = rq(3'h2, 18'h3_FFFE, 72'h0);
    nB = nA;
    go(1);
    nA = rq(3'h1, 18'h0, 72'h0);
    go(4);
    chk(rdDataA_ff, 72'hA_0001);
    chk(rdDataB_ff, 72'hA_0001);
    go(1);
    chk(rdDataA_ff, 72'hB_0002);
    chk({71'h0, rdOeNA_ff}, 72'h0);
    chk({71'h0, rdOeNB_ff}, 72'h0);
    chk({54'h0, burstAddrA_ff}, 72'h0);
    nA = '0;
    go(5);
    chk({71'h0, rdOeNA_ff}, 72'h1);
  endtask
  initial
  begin
    go(6);
    nrst = 1'h1;
    go(4);
    t_burst();
    tally_and_finish(0);
  end
endmodule // tb_top
